// ### pkg/sdo_pkg.sv
// constants of the segmented upload server: frame ids, command bytes,
// abort codes and buffer sizes
// assumes frames of eight bytes with byte 0 in bits 7:0
package sdo_pkg;
   localparam int          FRAME_BYTES   = 8;
   localparam int          FRAME_W       = 8 * FRAME_BYTES;
   localparam int          ID_W          = 11;
   localparam int          FIFO_DEPTH    = 8;
   localparam int          LEN_W         = 8;
   localparam logic [10:0] ID_REQ_BASE   = 11'h600;
   localparam logic [10:0] ID_RSP_BASE   = 11'h580;
   localparam logic [7:0]  CMD_INIT_REQ  = 8'h40;
   localparam logic [7:0]  CMD_INIT_RSP  = 8'h41;
   localparam logic [7:0]  CMD_EXP_RSP1  = 8'h4f;
   localparam logic [2:0]  CMD_SEG_REQ   = 3'h3;
   localparam logic [7:0]  CMD_ABORT     = 8'h80;
   localparam logic [2:0]  SEG_MAX       = 3'h7;
   localparam logic [2:0]  SEG_BASE      = 3'h1;
   localparam logic [2:0]  EXP_BASE      = 3'h4;
   localparam int          TOGGLE_BIT    = 4;
   localparam int          LAST_BIT      = 0;
   localparam logic [31:0] ABORT_TOGGLE  = 32'h05030000;
   localparam logic [31:0] ABORT_CMD     = 32'h05040001;
   localparam logic [31:0] ABORT_NO_OBJ  = 32'h06020000;
   localparam logic [31:0] ABORT_NO_SUB  = 32'h06090011;
   localparam logic [31:0] ABORT_GENERAL = 32'h08000000;
   localparam logic        TOG_RESET     = 1'b1;
   typedef enum logic [2:0] {K_DROP, K_ABORT_IN, K_ABORT_OUT, K_INIT, K_EXP, K_SEG} sdo_kind_e;
endpackage

// ### verification/sdo_client_model.sv
// client model: offers request frames, answers are accepted with stalls
// assumes the server's rx_ready_o is registered on clk_sys_i
`timescale 1ns/1ps
module sdo_client_model
   import sdo_pkg::*;
(
   input  wire logic                        clk_sys_i,
   input  wire logic                        stall_i,
   input  wire logic                        rx_ready_i,
   output logic                             rx_valid_o,
   output logic [sdo_pkg::ID_W-1:0]         rx_id_o,
   output logic [sdo_pkg::FRAME_W-1:0]      rx_data_o,
   output logic                             tx_ready_o
);
   int unsigned timeouts = 0;
   initial
   begin
      rx_valid_o = 1'b0;
      rx_id_o    = '0;
      rx_data_o  = '0;
      tx_ready_o = 1'b0;
   end
   always @(posedge clk_sys_i)
      tx_ready_o <= !stall_i;
   // whole eight-byte frame stands until taken or 2000 cycles pass, then lines show the inverse
   task automatic send(input logic [ID_W-1:0] id, input logic [FRAME_W-1:0] d);
      int n;
      n = 0;
      @(posedge clk_sys_i);
      rx_valid_o <= 1'b1;
      rx_id_o    <= id;
      rx_data_o  <= d;
      do
      begin
         @(negedge clk_sys_i);
         n++;
      end
      while (!rx_ready_i && n < 2000);
      if (!rx_ready_i)
         timeouts++;
      @(posedge clk_sys_i);
      rx_valid_o <= 1'b0;
      rx_id_o    <= ~id;
      rx_data_o  <= ~d;
   endtask
endmodule

// ### verification/tb_top.sv
// testbench of the segmented upload server with a client model
// assumes a combinational string store and random answer stalls
`timescale 1ns/1ps
module tb_top;
   import sdo_pkg::*;
   logic clk_sys_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic [6:0] node = 7'h01;
   logic [15:0] idx = 16'h0000;
   logic [7:0] len = 8'h00;
   logic [7:0] rd_addr, rd_data;
   logic rx_valid, rx_ready, tx_valid, tx_ready, busy;
   logic [ID_W-1:0] rx_id, tx_id;
   logic [FRAME_W-1:0] rx_data, tx_data;
   logic hold = 1'b1;
   logic stall = 1'b1;
   logic saw_full = 1'b0;
   logic [7:0] mem [256];
   logic [31:0] rs = 32'd89;
   logic [74:0] exp_q [$];
   int err_total = 0;
   int n_checks = 0;
   int lens [5] = '{17, 7, 8, 14, 0};
   assign rd_data = mem[rd_addr];
   initial
      forever #12.5 clk_sys_i = ~clk_sys_i;
   sdo_upload_server sdo_upload_server_i (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
      .node_id_i(node), .str_index_i(idx), .str_len_i(len), .str_rd_addr_o(rd_addr),
      .str_rd_data_i(rd_data), .rx_valid_i(rx_valid), .rx_ready_o(rx_ready),
      .rx_id_i(rx_id), .rx_data_i(rx_data), .tx_valid_o(tx_valid), .tx_ready_i(tx_ready),
      .tx_id_o(tx_id), .tx_data_o(tx_data), .busy_o(busy));
   sdo_client_model sdo_client_model_i (.clk_sys_i(clk_sys_i), .stall_i(stall),
      .rx_ready_i(rx_ready), .rx_valid_o(rx_valid), .rx_id_o(rx_id), .rx_data_o(rx_data),
      .tx_ready_o(tx_ready));
   function automatic logic [31:0] xs();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs;
   endfunction
   function automatic logic [63:0] fr(logic [7:0] c, logic [7:0] s, logic [31:0] d);
      return {d, s, idx, c};
   endfunction
   task automatic chk(string nm, logic [74:0] seen, logic [74:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // note the answer, then let the client offer the request
   task automatic req(logic [10:0] id, logic [63:0] rq, logic [63:0] ex, bit has);
      if (has)
         exp_q.push_back({ID_RSP_BASE + 11'(node), ex});
      sdo_client_model_i.send(id, rq);
   endtask
   // wait until every noted answer is seen and the server is idle
   task automatic settle();
      int i;
      i = 0;
      repeat (2) @(posedge clk_sys_i);
      while (i < 5000 && (exp_q.size() || busy !== 1'b0))
      begin
         @(posedge clk_sys_i);
         i++;
      end
      if (exp_q.size() || busy !== 1'b0)
         err_total++;
   endtask
   // initiate at subindex 00, then up to maxseg segment requests
   // string length only changes once earlier requests are served
   task automatic upload(int l, int maxseg);
      int pos, n, segs;
      logic t, last;
      logic [63:0] d;
      settle();
      pos = 0;
      segs = 0;
      t = 1'b0;
      last = 1'b0;
      @(posedge clk_sys_i);
      len <= 8'(l);
      req(ID_REQ_BASE + 11'(node), fr(8'h40, 8'h00, 32'h0),
          fr(8'h41, 8'h00, 32'(l)), 1);
      while (!last && segs < maxseg)
      begin
         n = (l - pos > 7) ? 7 : l - pos;
         last = (pos + n == l);
         d = '0;
         d[7:0] = {3'b000, t, 3'(7 - n), last};
         for (int k = 0; k < n; k++)
            d[8*(k+1) +: 8] = mem[pos + k];
         req(ID_REQ_BASE + 11'(node), fr({3'b011, t, 4'h0}, 8'h00, 32'h0), d, 1);
         pos += n;
         t = ~t;
         segs++;
      end
   endtask
   always @(posedge clk_sys_i)
      stall <= hold | (xs() % 3 == 0);
   always @(negedge clk_sys_i)
      if (arst_n_i && !rx_ready)
         saw_full = 1'b1;
   always @(posedge clk_sys_i)
      if (arst_n_i && tx_valid && tx_ready)
         chk("answer frame", {tx_id, tx_data}, exp_q.size() ? exp_q.pop_front() : '1);
   initial
   begin
      repeat (90000) @(posedge clk_sys_i);
      err_total++;
      results();
   end
   initial
   begin
      logic [10:0] rq;
      foreach (mem[i])
         mem[i] = xs() % 8'h5f + 8'h20;
      repeat (6) @(posedge clk_sys_i);
      chk("reset outputs", {rx_ready, tx_valid, busy}, 3'b100);
      arst_n_i <= 1'b1;
      node <= 7'(xs() % 127 + 1);
      idx <= 16'(xs());
      hold <= 1'b0;
      @(posedge clk_sys_i);
      rq = ID_REQ_BASE + 11'(node);
      foreach (lens[i])
         upload(lens[i], 9);
      upload(17, 0);
      for (int s = 1; s <= 17; s += 4)
         req(rq, fr(8'h40, 8'(s), 0), fr(8'h4f, 8'(s), {24'h0, mem[s-1]}), 1);
      upload(17, 1);
      req(rq, fr(8'h60, 8'h00, 0), fr(8'h80, 8'h00, ABORT_TOGGLE), 1);
      req(rq, fr(8'h60, 8'h00, 0), fr(8'h80, 8'h00, ABORT_GENERAL), 1);
      req(rq, fr(8'h70, 8'h00, 0), fr(8'h80, 8'h00, ABORT_GENERAL), 1);
      upload(17, 2);
      req(rq, fr(8'h80, 8'h00, xs()), 0, 0);
      req(rq, fr(8'h60, 8'h00, 0), fr(8'h80, 8'h00, ABORT_GENERAL), 1);
      upload(17, 9);
      req(rq + 11'h001, fr(8'h40, 8'h00, 0), 0, 0);
      req(rq, fr(8'h20, 8'h00, 0), fr(8'h80, 8'h00, ABORT_CMD), 1);
      hold <= 1'b1;
      fork
         repeat (12)
            req(rq, fr(8'h40, 8'h01, 0), fr(8'h4f, 8'h01, {24'h0, mem[0]}), 1);
         begin
            for (int i = 0; i < 3000 && !saw_full; i++)
               @(posedge clk_sys_i);
            @(posedge clk_sys_i);
            hold <= 1'b0;
         end
      join
      chk("buffer refused", saw_full, 1);
      settle();
      chk("answers left", exp_q.size(), 0);
      chk("client stalls", sdo_client_model_i.timeouts, 0);
      results();
   end
endmodule

// ### verilog/sdo_fifo.sv
// first-in first-out buffer of frames, flip-flop storage
// assumes one clock; full and empty are registered
`timescale 1ns/1ps
module sdo_fifo #(
   parameter int WIDTH = 75,
   parameter int DEPTH = 8
) (
   input  wire logic             clk_sys_i,
   input  wire logic             arst_n_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic [WIDTH-1:0]      out_data_o
);
   localparam int AW = $clog2(DEPTH);
   generate
      if (DEPTH < 2 || WIDTH < 1)
      begin : g_bad
         $error("sdo_fifo needs DEPTH >= 2 and WIDTH >= 1");
      end
   endgenerate

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_q;
   logic [AW-1:0]    rd_q;
   logic [AW:0]      cnt_q;
   logic [AW:0]      cnt_d;
   logic             ready_q;
   logic             empty_q;
   logic             push;
   logic             pop;

   assign push        = in_valid_i && ready_q;
   assign pop         = out_ready_i && !empty_q;
   assign in_ready_o  = ready_q;
   assign out_valid_o = !empty_q;
   assign out_data_o  = mem_q[rd_q];

   always_comb
   begin
      cnt_d = cnt_q;
      if (push && !pop)
         cnt_d = cnt_q + 1'b1;
      else if (pop && !push)
         cnt_d = cnt_q - 1'b1;
   end

   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         cnt_q   <= '0;
         ready_q <= 1'b1;
         empty_q <= 1'b1;
      end
      else
      begin
         cnt_q   <= cnt_d;
         ready_q <= (cnt_d != (AW+1)'(DEPTH));
         empty_q <= (cnt_d == '0);
      end
   end

   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         wr_q <= '0;
         rd_q <= '0;
      end
      else
      begin
         if (push)
            wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
         if (pop)
            rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (push)
         mem_q[wr_q] <= in_data_i;
   end
endmodule

// ### verilog/sdo_upload_server.sv
// segmented upload server for one string object of the object dictionary
// assumes frame ports and the string store run on clk_sys_i; the store
// answers str_rd_data_i combinationally from str_rd_addr_o
//
// Behaviour
// - subindex n expedited-reads character n
// - initiate at subindex 00 answers segmented
// - segments only after completed initiate
// - initiate answer 41, index, subindex, length
// - segment answer echoes request toggle
// - bits 3..1 give unused byte count
// - last segment sets the last flag
// - segment command byte packs toggle, count, last
// - abort is 80, index, subindex, code
// - abort ends transfer silently
// - abort code is ignored
// - requests 600 plus node, answers 580 plus node
// - every frame is eight bytes
// - repeated toggle aborts with 05030000
`timescale 1ns/1ps
module sdo_upload_server
   import sdo_pkg::*;
#(
   parameter int DEPTH = sdo_pkg::FIFO_DEPTH
) (
   input  wire logic                        clk_sys_i,
   input  wire logic                        arst_n_i,
   input  wire logic [6:0]                  node_id_i,
   input  wire logic [15:0]                 str_index_i,
   input  wire logic [sdo_pkg::LEN_W-1:0]   str_len_i,
   output logic [sdo_pkg::LEN_W-1:0]        str_rd_addr_o,
   input  wire logic [7:0]                  str_rd_data_i,
   input  wire logic                        rx_valid_i,
   output logic                             rx_ready_o,
   input  wire logic [sdo_pkg::ID_W-1:0]    rx_id_i,
   input  wire logic [sdo_pkg::FRAME_W-1:0] rx_data_i,
   output logic                             tx_valid_o,
   input  wire logic                        tx_ready_i,
   output logic [sdo_pkg::ID_W-1:0]         tx_id_o,
   output logic [sdo_pkg::FRAME_W-1:0]      tx_data_o,
   output logic                             busy_o
);
   import sdo_pkg::*;

   typedef enum logic [1:0] {ST_IDLE, ST_DECODE, ST_FETCH, ST_SEND} sdo_state_e;

   sdo_state_e         state_q;
   logic               f_valid;
   logic [ID_W-1:0]    f_id;
   logic [FRAME_W-1:0] f_data;
   logic [ID_W-1:0]    req_id_q;
   logic [FRAME_W-1:0] req_q;
   logic [FRAME_W-1:0] resp_q;
   logic               active_q;
   logic               last_tog_q;
   logic [LEN_W-1:0]   pos_q;
   logic [15:0]        xidx_q;
   logic [7:0]         xsub_q;
   logic [2:0]         k_q;
   logic [2:0]         n_q;
   logic [2:0]         base_q;
   logic               tx_valid_q;
   logic [ID_W-1:0]    req_base;
   logic [7:0]         cmd;
   logic [15:0]        idx;
   logic [7:0]         sub;
   logic               hit;
   logic               is_seg;
   logic [LEN_W-1:0]   remain;
   logic [2:0]         seg_n;
   logic               seg_last;
   sdo_kind_e          kind;
   logic [31:0]        code;
   logic [15:0]        ab_idx;
   logic [7:0]         ab_sub;

   sdo_fifo #(.WIDTH(ID_W + FRAME_W), .DEPTH(DEPTH)) u_rx_fifo (
      .clk_sys_i   (clk_sys_i),
      .arst_n_i    (arst_n_i),
      .in_valid_i  (rx_valid_i),
      .in_ready_o  (rx_ready_o),
      .in_data_i   ({rx_id_i, rx_data_i}),
      .out_valid_o (f_valid),
      .out_ready_i (state_q == ST_IDLE),
      .out_data_o  ({f_id, f_data})
   );

   assign req_base = ID_REQ_BASE + {4'h0, node_id_i};
   assign cmd      = req_q[7:0];
   assign idx      = req_q[23:8];
   assign sub      = req_q[31:24];
   assign hit      = (req_id_q == req_base);
   assign is_seg   = (cmd[7:5] == CMD_SEG_REQ) && (cmd[3:0] == 4'h0);
   assign remain   = str_len_i - pos_q;
   assign seg_last = (remain <= LEN_W'(SEG_MAX));
   assign seg_n    = seg_last ? remain[2:0] : SEG_MAX;

   // classify the request taken from the buffer
   always_comb
   begin
      kind   = K_DROP;
      code   = ABORT_CMD;
      ab_idx = idx;
      ab_sub = sub;
      if (hit)
      begin
         if (cmd == CMD_ABORT)
            kind = K_ABORT_IN;
         else if (cmd == CMD_INIT_REQ)
         begin
            if (idx != str_index_i)
            begin
               kind = K_ABORT_OUT;
               code = ABORT_NO_OBJ;
            end
            else if (sub == 8'h00)
               kind = K_INIT;
            else if (sub <= str_len_i)
               kind = K_EXP;
            else
            begin
               kind = K_ABORT_OUT;
               code = ABORT_NO_SUB;
            end
         end
         else if (is_seg)
         begin
            ab_idx = xidx_q;
            ab_sub = xsub_q;
            kind   = K_ABORT_OUT;
            if (!active_q)
            begin
               code   = ABORT_GENERAL;
               ab_idx = idx;
               ab_sub = sub;
            end
            else if (cmd[TOGGLE_BIT] == last_tog_q)
               code = ABORT_TOGGLE;
            else
               kind = K_SEG;
         end
         else
            kind = K_ABORT_OUT;
      end
   end

   // sequencing
   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         state_q <= ST_IDLE;
      else
      begin
         case (state_q)
            ST_IDLE:
               if (f_valid)
                  state_q <= ST_DECODE;
            ST_DECODE:
               case (kind)
                  K_DROP, K_ABORT_IN: state_q <= ST_IDLE;
                  K_EXP:              state_q <= ST_FETCH;
                  K_SEG:              state_q <= (seg_n == 3'h0) ? ST_SEND : ST_FETCH;
                  default:            state_q <= ST_SEND;
               endcase
            ST_FETCH:
               if (k_q + 3'h1 == n_q)
                  state_q <= ST_SEND;
            ST_SEND:
               if (!tx_valid_q || tx_ready_i)
                  state_q <= ST_IDLE;
            default:
               state_q <= ST_IDLE;
         endcase
      end
   end

   // request capture
   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         req_id_q <= '0;
         req_q    <= '0;
      end
      else if (state_q == ST_IDLE && f_valid)
      begin
         req_id_q <= f_id;
         req_q    <= f_data;
      end
   end

   // transfer state
   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         active_q   <= 1'b0;
         last_tog_q <= TOG_RESET;
         pos_q      <= '0;
         xidx_q     <= '0;
         xsub_q     <= '0;
      end
      else if (state_q == ST_DECODE)
      begin
         case (kind)
            K_INIT:
            begin
               active_q   <= 1'b1;
               last_tog_q <= TOG_RESET;
               pos_q      <= '0;
               xidx_q     <= idx;
               xsub_q     <= sub;
            end
            K_SEG:
            begin
               last_tog_q <= cmd[TOGGLE_BIT];
               pos_q      <= pos_q + LEN_W'(seg_n);
               if (seg_last)
                  active_q <= 1'b0;
            end
            K_DROP:
               active_q <= active_q;
            default:
            begin
               active_q <= 1'b0;
               pos_q    <= '0;
            end
         endcase
      end
   end

   // answer assembly and string fetch
   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         resp_q        <= '0;
         str_rd_addr_o <= '0;
         k_q           <= '0;
         n_q           <= '0;
         base_q        <= '0;
      end
      else if (state_q == ST_DECODE)
      begin
         k_q <= '0;
         case (kind)
            K_INIT:
               resp_q <= {24'h0, str_len_i, sub, idx, CMD_INIT_RSP};
            K_EXP:
            begin
               resp_q        <= {32'h0, sub, idx, CMD_EXP_RSP1};
               str_rd_addr_o <= sub - 8'h01;
               n_q           <= 3'h1;
               base_q        <= EXP_BASE;
            end
            K_SEG:
            begin
               resp_q        <= {56'h0, 3'h0, cmd[TOGGLE_BIT],
                                 SEG_MAX - seg_n, seg_last};
               str_rd_addr_o <= pos_q;
               n_q           <= seg_n;
               base_q        <= SEG_BASE;
            end
            K_ABORT_OUT:
               resp_q <= {code, ab_sub, ab_idx, CMD_ABORT};
            default:
               resp_q <= resp_q;
         endcase
      end
      else if (state_q == ST_FETCH)
      begin
         resp_q[{base_q + k_q, 3'h0} +: 8] <= str_rd_data_i;
         str_rd_addr_o <= str_rd_addr_o + 8'h01;
         k_q           <= k_q + 3'h1;
      end
   end

   // transmit slot, always eight bytes
   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         tx_valid_q <= 1'b0;
         tx_id_o    <= '0;
         tx_data_o  <= '0;
      end
      else if (state_q == ST_SEND && (!tx_valid_q || tx_ready_i))
      begin
         tx_valid_q <= 1'b1;
         tx_id_o    <= ID_RSP_BASE + {4'h0, node_id_i};
         tx_data_o  <= resp_q;
      end
      else if (tx_ready_i)
         tx_valid_q <= 1'b0;
   end

   assign tx_valid_o = tx_valid_q;

   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         busy_o <= 1'b0;
      else
         busy_o <= (state_q != ST_IDLE) || f_valid;
   end

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!arst_n_i);

   chk_tx_resp_id: assert property (
      tx_valid_o |-> tx_id_o == ID_RSP_BASE + {4'h0, node_id_i})
      else $error("answer id wrong");
   chk_tx_hold: assert property (
      tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
      else $error("answer dropped before taken");
   chk_init_answer: assert property (
      state_q == ST_DECODE && hit && cmd == CMD_INIT_REQ && idx == str_index_i && sub == 8'h00
      |=> resp_q[7:0] == CMD_INIT_RSP && resp_q[39:32] == $past(str_len_i) && active_q)
      else $error("initiate answer wrong");
   chk_seg_toggle: assert property (
      state_q == ST_DECODE && kind == K_SEG
      |=> resp_q[TOGGLE_BIT] == $past(cmd[TOGGLE_BIT]))
      else $error("toggle not echoed");
   chk_seg_unused: assert property (
      state_q == ST_DECODE && kind == K_SEG
      |=> resp_q[3:1] == (($past(remain) > 8'h07) ? 3'h0 : 3'(8'h07 - $past(remain)))
          && resp_q[LAST_BIT] == ($past(remain) <= 8'h07))
      else $error("segment command byte wrong");
   chk_pos_advance: assert property (
      state_q == ST_DECODE && kind == K_SEG
      |=> pos_q == $past(pos_q) + 8'($past(seg_n)))
      else $error("position not advanced");
   chk_toggle_abort: assert property (
      state_q == ST_DECODE && hit && is_seg && active_q && cmd[TOGGLE_BIT] == last_tog_q
      |=> resp_q[63:32] == ABORT_TOGGLE && resp_q[7:0] == CMD_ABORT && !active_q)
      else $error("repeated toggle not aborted");
   chk_idle_seg_abort: assert property (
      state_q == ST_DECODE && hit && is_seg && !active_q
      |=> resp_q[7:0] == CMD_ABORT && resp_q[63:32] == ABORT_GENERAL && state_q == ST_SEND)
      else $error("segment without transfer not aborted");
   chk_abort_silent: assert property (
      state_q == ST_DECODE && hit && cmd == CMD_ABORT
      |=> state_q == ST_IDLE && !active_q && pos_q == '0)
      else $error("abort not silent");
   chk_exp_addr: assert property (
      state_q == ST_DECODE && kind == K_EXP
      |=> str_rd_addr_o == $past(sub) - 8'h01 ##1 resp_q[39:32] == $past(str_rd_data_i))
      else $error("expedited character wrong");

   cov_init: cover property (state_q == ST_DECODE && kind == K_INIT);
   cov_last_seg: cover property (state_q == ST_DECODE && kind == K_SEG && seg_last);
   cov_abort_in: cover property (state_q == ST_DECODE && kind == K_ABORT_IN && active_q);
   cov_fifo_full: cover property (!rx_ready_o);
endmodule
